// ### src/mics_pkg.sv
// Package with register map, field layout, states and carriers of the ident sequencer
`default_nettype none
package mics_pkg;
    // Register byte offsets on the APB
    localparam logic [7:0] ADDR_CUR_CMD = 8'h00;
    localparam logic [7:0] ADDR_ENC_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_CUR_GAIN = 8'h14;
    localparam logic [7:0] ADDR_CUR_TCONST = 8'h18;
    localparam logic [7:0] ADDR_ENC_RES = 8'h1c;
    // Command register fields
    localparam int CMD_START_BIT = 0;
    localparam int CMD_BUSY_BIT = 0;
    localparam int CMD_OK_BIT = 1;
    localparam int CMD_ERR_BIT = 2;
    // Status word bit positions within one half
    localparam int HALF_W = 16;
    localparam int ST_SUM_BIT = 0;
    localparam int ST_CTRL_BIT = 1;
    localparam int ST_PWR_BIT = 2;
    localparam int ST_LIM_BIT = 15;
    // Engine cause bits accepted per half
    localparam logic [15:0] CUR_CAUSE_MASK = 16'h0018;
    localparam logic [15:0] ENC_CAUSE_MASK = 16'h07f8;
    // Reset values
    localparam logic [31:0] STATUS_RST = 32'h0000_0000;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;
    localparam logic [1:0] IRQ_ST_RST = 2'h0;
    // Sequencer states, Gray along idle-check-run-end
    typedef enum logic [1:0] {
        MICS_IDLE = 2'b00,
        MICS_CHECK = 2'b01,
        MICS_RUN = 2'b11,
        MICS_END = 2'b10
    } mics_state_t;
    // Current controller results
    typedef struct packed {
        logic [31:0] gain;
        logic [31:0] tconst;
    } mics_cur_res_t;
    // Encoder results
    typedef struct packed {
        logic phase_seq;
        logic [7:0] poles;
        logic [15:0] offset;
    } mics_enc_res_t;
    // Engine completion report
    typedef struct packed {
        logic done;
        logic fail;
        logic limited;
        logic [15:0] cause;
    } mics_eng_rpt_t;
endpackage
`default_nettype wire

// ### src/mics_top.sv
// Motor identification command sequencer with APB registers and interrupt
// Notes on behaviour
// - A command ends normally when identification succeeds and with an error flag otherwise.
// - Status bits 15 to 0 carry causes from the current controller command.
// - Status bits 31 to 16 carry causes from the encoder command.
// - A failing command always sets its half's summary bit, bit 0 or bit 16.
// - A good current command stores the controller gain and time constant.
// - A good encoder command stores pole count, offset angle and phase sequence.
// - The status word is updated and readable while a command is still running.
// - Bit 1 or bit 17 is set when the controller was enabled at command start.
// - Bit 2 or bit 18 is set when the power stage dropped during execution.
// - Bit 15 is set when the current command ends without failure but with limited parameters.
`default_nettype none
module mics_top
    import mics_pkg::*;
(
    input wire logic clk_in, // 100 MHz clock
    input wire logic rst_b_in, // Async reset, active low
    input wire logic psel_in, // APB select
    input wire logic penable_in, // APB enable
    input wire logic pwrite_in, // APB write
    input wire logic [7:0] paddr_in, // APB byte address
    input wire logic [31:0] pwdata_in, // APB write data
    output logic [31:0] prdata_out, // APB read data
    output logic pready_out, // APB ready
    output logic pslverr_out, // APB error on unmapped address
    input wire logic power_stage_enable_input_in, // Power stage enable pin
    input wire logic controller_enable_input_in, // Controller enable pin
    input wire logic class_one_diagnostic_errors_in, // Diagnostic error state
    output logic ident_start_out, // Pulse starting the engine
    output logic ident_abort_out, // Pulse aborting the engine
    output logic ident_sel_out, // 0 current, 1 encoder
    input wire mics_eng_rpt_t eng_rpt_in, // Engine report
    input wire mics_cur_res_t cur_res_in, // Current results
    input wire mics_enc_res_t enc_res_in, // Encoder results
    output logic irq_out // Level interrupt
);

    // Bit of a given half selected by command
    function automatic logic [31:0] half_bit(input logic sel, input int pos);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[pos + (sel ? HALF_W : 0)] = 1'b1;
        return v;
    endfunction

    // Place 16 bits into the selected half
    function automatic logic [31:0] to_half(input logic sel, input logic [15:0] bits);
        return sel ? {bits, 16'h0000} : {16'h0000, bits};
    endfunction

    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic pwr_ok;
    logic ctrl_on;
    logic diag_err;
    mics_state_t state_reg;
    logic sel_reg;
    logic fail_reg;
    logic [31:0] status_reg;
    logic [1:0] busy_reg;
    logic [1:0] ok_reg;
    logic [1:0] err_reg;
    logic [1:0] irq_st_reg;
    logic [1:0] irq_mask_reg;
    logic [1:0] irq_clr_reg;
    logic [31:0] gain_reg;
    logic [31:0] tconst_reg;
    mics_enc_res_t enc_reg;
    logic setup;
    logic acc;
    logic acc_wr;
    logic start_req;
    logic start_sel;
    logic chk_fail;
    logic [31:0] chk_bits;
    logic run_drop;
    logic run_done;
    logic [15:0] cause_mask;
    logic [31:0] rdata_next;
    logic hit_next;

    // Two-flop synchronisers for the pins
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end else begin
            pin_meta_reg <= {class_one_diagnostic_errors_in, controller_enable_input_in,
                             power_stage_enable_input_in};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign pwr_ok = pin_sync_reg[0];
    assign ctrl_on = pin_sync_reg[1];
    assign diag_err = pin_sync_reg[2];

    // APB phases; access completes on the cycle after setup
    assign setup = psel_in && !penable_in;
    assign acc = psel_in && penable_in && pready_out;
    assign acc_wr = acc && pwrite_in;

    // Start request from a command register write while idle
    assign start_req = acc_wr && pwdata_in[CMD_START_BIT] && (state_reg == MICS_IDLE) &&
                       (paddr_in == ADDR_CUR_CMD || paddr_in == ADDR_ENC_CMD);
    assign start_sel = (paddr_in == ADDR_ENC_CMD);

    // Precondition check; controller enable has priority over power and errors
    always_comb begin
        chk_fail = 1'b1;
        chk_bits = half_bit(sel_reg, ST_SUM_BIT);
        if (ctrl_on) begin
            chk_bits = chk_bits | half_bit(sel_reg, ST_CTRL_BIT);
        end else if (!pwr_ok) begin
            chk_bits = chk_bits | half_bit(sel_reg, ST_PWR_BIT);
        end else if (diag_err) begin
            chk_bits = chk_bits;
        end else begin
            chk_fail = 1'b0;
            chk_bits = 32'h0000_0000;
        end
    end

    // Run phase events
    assign run_drop = (state_reg == MICS_RUN) && !pwr_ok;
    assign run_done = (state_reg == MICS_RUN) && pwr_ok && eng_rpt_in.done;
    assign cause_mask = sel_reg ? ENC_CAUSE_MASK : CUR_CAUSE_MASK;

    // Sequencer state machine
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= MICS_IDLE;
            sel_reg <= 1'b0;
            fail_reg <= 1'b0;
        end else begin
            case (state_reg)
                MICS_IDLE: begin
                    if (start_req) begin
                        state_reg <= MICS_CHECK;
                        sel_reg <= start_sel;
                        fail_reg <= 1'b0;
                    end
                end
                MICS_CHECK: begin
                    fail_reg <= chk_fail;
                    state_reg <= chk_fail ? MICS_END : MICS_RUN;
                end
                MICS_RUN: begin
                    if (run_drop) begin
                        fail_reg <= 1'b1;
                        state_reg <= MICS_END;
                    end else if (run_done) begin
                        fail_reg <= eng_rpt_in.fail;
                        state_reg <= MICS_END;
                    end
                end
                MICS_END: begin
                    state_reg <= MICS_IDLE;
                end
                default: begin
                    state_reg <= MICS_IDLE;
                end
            endcase
        end
    end

    // Status word: cleared per half at start, causes merged live during run
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            status_reg <= STATUS_RST;
        end else if (start_req) begin
            status_reg <= status_reg & ~to_half(start_sel, 16'hffff);
        end else if (state_reg == MICS_CHECK) begin
            status_reg <= status_reg | chk_bits;
        end else if (state_reg == MICS_RUN) begin
            if (run_drop) begin
                status_reg <= status_reg | half_bit(sel_reg, ST_PWR_BIT) |
                              half_bit(sel_reg, ST_SUM_BIT);
            end else if (run_done && eng_rpt_in.fail) begin
                status_reg <= status_reg | to_half(sel_reg, eng_rpt_in.cause & cause_mask) |
                              half_bit(sel_reg, ST_SUM_BIT);
            end else if (run_done && eng_rpt_in.limited && !sel_reg) begin
                status_reg <= status_reg | to_half(sel_reg, eng_rpt_in.cause & cause_mask) |
                              half_bit(1'b0, ST_LIM_BIT);
            end else begin
                status_reg <= status_reg | to_half(sel_reg, eng_rpt_in.cause & cause_mask);
            end
        end
    end

    // Engine control pulses
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ident_start_out <= 1'b0;
            ident_abort_out <= 1'b0;
            ident_sel_out <= 1'b0;
        end else begin
            ident_start_out <= (state_reg == MICS_CHECK) && !chk_fail;
            ident_abort_out <= run_drop;
            ident_sel_out <= (state_reg == MICS_IDLE && start_req) ? start_sel : sel_reg;
        end
    end

    // Result storage on a good finish
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gain_reg <= 32'h0000_0000;
            tconst_reg <= 32'h0000_0000;
            enc_reg <= '0;
        end else if (run_done && !eng_rpt_in.fail) begin
            if (!sel_reg) begin
                gain_reg <= cur_res_in.gain;
                tconst_reg <= cur_res_in.tconst;
            end else begin
                enc_reg <= enc_res_in;
            end
        end
    end

    // Per-command busy, ok and error flags
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_reg <= 2'h0;
            ok_reg <= 2'h0;
            err_reg <= 2'h0;
        end else if (start_req) begin
            busy_reg[start_sel] <= 1'b1;
            ok_reg[start_sel] <= 1'b0;
            err_reg[start_sel] <= 1'b0;
        end else if (state_reg == MICS_END) begin
            busy_reg[sel_reg] <= 1'b0;
            ok_reg[sel_reg] <= !fail_reg;
            err_reg[sel_reg] <= fail_reg;
        end
    end

    // Sticky interrupt status; a completion beats a read clear
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_st_reg <= IRQ_ST_RST;
        end else begin
            irq_st_reg <= (irq_st_reg & ~((acc && !pwrite_in && paddr_in == ADDR_IRQ_ST) ?
                          irq_clr_reg : 2'h0)) |
                          ((state_reg == MICS_END) ? (sel_reg ? 2'h2 : 2'h1) : 2'h0);
        end
    end

    // Mask register and interrupt output
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_mask_reg <= IRQ_MASK_RST;
            irq_out <= 1'b0;
        end else begin
            if (acc_wr && paddr_in == ADDR_IRQ_MASK) begin
                irq_mask_reg <= pwdata_in[1:0];
            end
            irq_out <= |(irq_st_reg & irq_mask_reg);
        end
    end

    // Read mux
    always_comb begin
        hit_next = 1'b1;
        rdata_next = 32'h0000_0000;
        case (paddr_in)
            ADDR_CUR_CMD: rdata_next = {29'h0, err_reg[0], ok_reg[0], busy_reg[0]};
            ADDR_ENC_CMD: rdata_next = {29'h0, err_reg[1], ok_reg[1], busy_reg[1]};
            ADDR_STATUS: rdata_next = status_reg;
            ADDR_IRQ_ST: rdata_next = {30'h0, irq_st_reg};
            ADDR_IRQ_MASK: rdata_next = {30'h0, irq_mask_reg};
            ADDR_CUR_GAIN: rdata_next = gain_reg;
            ADDR_CUR_TCONST: rdata_next = tconst_reg;
            ADDR_ENC_RES: rdata_next = {7'h0, enc_reg};
            default: hit_next = 1'b0;
        endcase
    end

    // APB answer registered at setup, shown during access
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            irq_clr_reg <= 2'h0;
        end else begin
            pready_out <= setup;
            pslverr_out <= setup && !hit_next;
            if (setup) begin
                prdata_out <= pwrite_in ? 32'h0000_0000 : rdata_next;
                irq_clr_reg <= irq_st_reg;
            end
        end
    end

    default clocking mics_cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence start_seq;
        start_req ##1 (state_reg == MICS_CHECK);
    endsequence

    sequence end_seq;
        (state_reg == MICS_END) ##1 (state_reg == MICS_IDLE);
    endsequence

    ctrl_start_bit_a: assert property (
        (state_reg == MICS_CHECK) && ctrl_on |=> (state_reg == MICS_END) && fail_reg &&
        status_reg[ST_CTRL_BIT + (sel_reg ? HALF_W : 0)])
        else $error("controller-enabled start not flagged");

    refuse_start_a: assert property (
        (state_reg == MICS_CHECK) && (ctrl_on || !pwr_ok || diag_err) |=> !ident_start_out
        ##1 (state_reg == MICS_IDLE) && err_reg[sel_reg])
        else $error("bad precondition start not refused");

    power_drop_a: assert property (
        run_drop |=> ident_abort_out && (state_reg == MICS_END) &&
        status_reg[ST_PWR_BIT + (sel_reg ? HALF_W : 0)])
        else $error("power loss during run not flagged");

    summary_bit_a: assert property (
        (state_reg == MICS_END) && fail_reg |-> status_reg[sel_reg ? HALF_W : ST_SUM_BIT])
        else $error("summary bit missing on failure");

    clear_half_a: assert property (
        start_seq |-> ((sel_reg ? status_reg[31:16] : status_reg[15:0]) == 16'h0000))
        else $error("status half not cleared at start");

    cur_store_a: assert property (
        run_done && !eng_rpt_in.fail && !sel_reg |=> gain_reg == $past(cur_res_in.gain) &&
        tconst_reg == $past(cur_res_in.tconst))
        else $error("current results not stored");

    enc_store_a: assert property (
        run_done && !eng_rpt_in.fail && sel_reg |=> enc_reg == $past(enc_res_in))
        else $error("encoder results not stored");

    live_cause_a: assert property (
        (state_reg == MICS_RUN) && !run_drop && !sel_reg |=>
        ((status_reg[15:0] & $past(eng_rpt_in.cause & CUR_CAUSE_MASK)) ==
        $past(eng_rpt_in.cause & CUR_CAUSE_MASK)))
        else $error("running causes not shown");

    enc_cause_a: assert property (
        (state_reg == MICS_RUN) && !run_drop && sel_reg |=>
        ((status_reg[31:16] & $past(eng_rpt_in.cause & ENC_CAUSE_MASK)) ==
        $past(eng_rpt_in.cause & ENC_CAUSE_MASK)))
        else $error("encoder causes not in upper half");

    limit_bit_a: assert property (
        run_done && !eng_rpt_in.fail && eng_rpt_in.limited && !sel_reg |=>
        status_reg[ST_LIM_BIT] ##1 ok_reg[0])
        else $error("limited parameters not flagged");

    finish_flag_a: assert property (
        end_seq |-> !busy_reg[$past(sel_reg)] &&
        (ok_reg[$past(sel_reg)] != err_reg[$past(sel_reg)]) &&
        (err_reg[$past(sel_reg)] == $past(fail_reg)))
        else $error("command end not reported");

endmodule
`default_nettype wire

// ### verification/mics_eng_model.sv
// Behavioural identification engine that answers the sequencer
`default_nettype none
module mics_eng_model import mics_pkg::*; (
    input wire logic clk_in, // Clock
    input wire logic rst_b_in, // Async reset, active low
    input wire logic start_in, // Start pulse
    input wire logic abort_in, // Abort pulse
    input wire logic [7:0] dly_in, // Run length in cycles
    input wire logic fail_in, // End with failure
    input wire logic lim_in, // End with limited results
    input wire logic [15:0] cause_in, // Causes shown while running
    input wire mics_cur_res_t cur_in, // Current results to hand over
    input wire mics_enc_res_t enc_in, // Encoder results to hand over
    output var mics_eng_rpt_t rpt_out, // Report to sequencer
    output var mics_cur_res_t cur_out, // Current results
    output var mics_enc_res_t enc_out // Encoder results
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_reg;
    logic [7:0] cnt_reg;
    logic fin;
    // One run counts down; an abort stops it at once
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_reg <= 1'b0;
            cnt_reg <= 8'h00;
        end else if (start_in) begin
            busy_reg <= 1'b1;
            cnt_reg <= dly_in;
        end else if (abort_in || fin) begin
            busy_reg <= 1'b0;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end
    // Results hold only with done, otherwise the inverse so stale data never passes
    assign fin = busy_reg && cnt_reg == 8'h00;
    assign rpt_out = {fin, fin && fail_in, fin && lim_in, busy_reg ? cause_in : 16'h0000};
    assign cur_out = fin ? cur_in : ~cur_in;
    assign enc_out = fin ? enc_in : ~enc_in;
endmodule
`default_nettype wire

// ### verification/tb_motor_ident_command_sequencer.sv
// Self-checking testbench of the ident sequencer over APB
`default_nettype none
module tb_motor_ident_command_sequencer import mics_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, rst_b_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pwr = 1'b0, ctl = 1'b0, dia = 1'b0, e_fail = 1'b0, e_lim = 1'b0;
    logic [7:0] paddr = 8'h00, e_dly = 8'h05;
    logic [31:0] pwdata = 32'h0, prdata_out;
    logic [15:0] e_cause = 16'h0;
    logic pready_out, pslverr_out, st_p, ab_p, irq_out, sel_w, exp_sel = 1'b0;
    mics_cur_res_t e_cur = '0, cur_w;
    mics_enc_res_t e_enc = '0, enc_w;
    mics_eng_rpt_t rpt_w;
    logic [64:0] q[$];
    logic [64:0] note;
    int fails = 0, total_checks = 0, n_start = 0, n_abort = 0, seed = 32'h99b2;
    mics_top dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .power_stage_enable_input_in(pwr), .controller_enable_input_in(ctl),
        .class_one_diagnostic_errors_in(dia), .ident_start_out(st_p),
        .ident_abort_out(ab_p), .ident_sel_out(sel_w), .eng_rpt_in(rpt_w),
        .cur_res_in(cur_w), .enc_res_in(enc_w), .irq_out(irq_out));
    mics_eng_model eng_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .start_in(st_p),
        .abort_in(ab_p), .dly_in(e_dly), .fail_in(e_fail), .lim_in(e_lim),
        .cause_in(e_cause), .cur_in(e_cur), .enc_in(e_enc), .rpt_out(rpt_w),
        .cur_out(cur_w), .enc_out(enc_w));
    // 100 MHz clock
    always #5 clk_in = ~clk_in;
    task automatic chk(input logic [32:0] s, input logic [32:0] x);
        total_checks++;
        if (s !== x) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // One APB transfer; a read leaves its note {slverr, mask, data} for the monitor
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [64:0] x);
        int n;
        n = 0;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        if (!w) q.push_back(x);
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_in);
        end
        if (n == 50) fails++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 65'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(a, 1'b0, 32'h0, {1'b0, 32'hffffffff, x});
    endtask
    // Status read that compares only the half of command s
    task automatic rdh(input int s, input logic [15:0] h);
        apb(ADDR_STATUS, 1'b0, 32'h0,
            {1'b0, s ? 32'hffff0000 : 32'h0000ffff, {16'h0, h} << (16 * s)});
    endtask
    // Start command s; mode 1 drops the power stage, mode 2 reads status mid-run
    task automatic run(input int s, input int mode, input logic [31:0] cx);
        int n;
        n = 0;
        exp_sel <= (s != 0);
        wr(s ? ADDR_ENC_CMD : ADDR_CUR_CMD, 32'h1);
        if (mode == 1) begin
            repeat (6) @(posedge clk_in);
            pwr <= 1'b0;
        end
        if (mode == 2) begin
            wr(ADDR_ENC_CMD, 32'h1);
            rd(ADDR_STATUS, {16'h0, e_cause & CUR_CAUSE_MASK});
        end
        while (irq_out !== 1'b1 && n < 300) begin
            @(negedge clk_in);
            n++;
        end
        if (n == 300) fails++;
        @(posedge clk_in);
        rd(ADDR_IRQ_ST, 32'(s + 1));
        rd(s ? ADDR_ENC_CMD : ADDR_CUR_CMD, cx);
    endtask
    // Monitor takes the oldest note at the edge that completes a read access
    always @(posedge clk_in) begin
        if (psel && penable && pready_out === 1'b1 && !pwrite) begin
            note = q.pop_front();
            chk({pslverr_out, prdata_out & note[63:32]}, {note[64], note[31:0]});
        end
        if (st_p === 1'b1) begin
            n_start++;
            chk({32'h0, sel_w}, {32'h0, exp_sel});
        end
        if (ab_p === 1'b1) n_abort++;
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_in);
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rd(ADDR_STATUS, STATUS_RST);
        rd(ADDR_IRQ_ST, 32'h0);
        rd(ADDR_IRQ_MASK, 32'h0);
        apb(8'h20, 1'b0, 32'h0, {1'b1, 64'h0});
        wr(ADDR_IRQ_MASK, 32'h3);
        pwr <= 1'b1;
        e_lim <= 1'b1;
        e_cur <= {$random(seed), $random(seed)};
        e_enc <= 25'($random(seed));
        repeat (4) @(posedge clk_in);
        run(0, 0, 32'h2);
        rd(ADDR_CUR_GAIN, e_cur.gain);
        rd(ADDR_CUR_TCONST, e_cur.tconst);
        run(1, 0, 32'h2);
        rd(ADDR_ENC_RES, {7'h0, e_enc});
        rd(ADDR_STATUS, 32'h0000_8000);
        // Failing runs with random causes
        e_fail <= 1'b1;
        e_dly <= 8'd40;
        e_cause <= 16'($random(seed)) | 16'h0008;
        run(0, 2, 32'h4);
        e_dly <= 8'd5;
        run(1, 0, 32'h4);
        rd(ADDR_STATUS, {e_cause & ENC_CAUSE_MASK | 16'h1,
            e_cause & CUR_CAUSE_MASK | 16'h1});
        // Power stage lost in mid-run
        e_fail <= 1'b0;
        e_cause <= 16'h0;
        e_dly <= 8'd100;
        for (int s = 0; s < 2; s++) begin
            run(s, 1, 32'h4);
            rdh(s, 16'h5);
            pwr <= 1'b1;
            repeat (4) @(posedge clk_in);
        end
        // Refused starts, checked in priority order
        for (int c = 0; c < 3; c++) begin
            for (int s = 0; s < 2; s++) begin
                ctl <= (c == 0);
                pwr <= (c == 2);
                dia <= 1'b1;
                repeat (4) @(posedge clk_in);
                run(s, 0, 32'h4);
                rdh(s, c == 0 ? 16'h3 : (c == 1 ? 16'h5 : 16'h1));
            end
        end
        // Masked event leaves the interrupt low but sets its status
        ctl <= 1'b0;
        pwr <= 1'b1;
        wr(ADDR_IRQ_MASK, 32'h0);
        repeat (4) @(posedge clk_in);
        wr(ADDR_CUR_CMD, 32'h1);
        repeat (8) @(posedge clk_in);
        chk({32'h0, irq_out}, 33'h0);
        rd(ADDR_IRQ_ST, 32'h1);
        dia <= 1'b0;
        chk(33'(n_start), 33'd6);
        chk(33'(n_abort), 33'd2);
        tally_and_finish();
    end
endmodule
`default_nettype wire
